// File: rtl/vrwt_pkg.sv
// constants and types for the video-RAM wait/acknowledge and row-strobe timing block
package vrwt_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_OPTIONS = 4'h0;  // option word, a write is programming
  localparam logic [3:0] OFS_STATUS  = 4'h4;  // refresh counter and mode state

  // ---------------------------------------------------------------
  // option word field positions
  // ---------------------------------------------------------------
  localparam int OPT_W        = 11;
  localparam int POS_REFTIME  = 0;   // refresh_strobe_timing_sel, 2 bits
  localparam int POS_FIRSTDLY = 2;   // first_access_delay_sel, 2 bits
  localparam int POS_BURST    = 4;   // burst_wait_sel, 2 bits
  localparam int POS_XWAIT    = 6;   // extra_wait_count_sel
  localparam int POS_STYLE    = 7;   // handshake_style_sel
  localparam int POS_STAGGER  = 9;   // stagger_refresh_sel
  localparam int POS_SCRUB    = 10;  // error scrubbing mode select
  localparam logic [10:0] OPT_RESET = 11'h000;

  // ---------------------------------------------------------------
  // status word layout
  // ---------------------------------------------------------------
  localparam int POS_TESTMODE = 24;  // above the 24-bit refresh counter

  // ---------------------------------------------------------------
  // refresh strobe low and precharge, in positive edges
  // ---------------------------------------------------------------
  localparam logic [2:0] LOW_00 = 3'h2;
  localparam logic [2:0] PRE_00 = 3'h1;
  localparam logic [2:0] LOW_01 = 3'h3;
  localparam logic [2:0] PRE_01 = 3'h2;
  localparam logic [2:0] LOW_10 = 3'h2;
  localparam logic [2:0] PRE_10 = 3'h2;
  localparam logic [2:0] LOW_11 = 3'h4;
  localparam logic [2:0] PRE_11 = 3'h3;
  localparam logic [2:0] STAGGER_SPAN = 3'h3;  // last of four strobes starts 3 edges late

  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCESS,
    ST_REFRESH,
    ST_PRECHARGE
  } vrwt_state_e;

endpackage

// File: rtl/vrwt_timing.sv
// video-RAM access handshake, row/column strobe and refresh timing controller
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module vrwt_timing #(
  parameter int CNT_W = 24,  // refresh counter width
  parameter int LO_W  = 13   // low half of the counter in test mode
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdData,
  // processor side pins (asynchronous)
  input  wire logic        accessRequestN,
  input  wire logic        extraWaitInN,
  input  wire logic        refreshRequestN,
  input  wire logic        secondPortGrant,
  // array side selection pins (asynchronous)
  input  wire logic [1:0]  columnStrobeEnableN,
  input  wire logic [1:0]  bankSelectInputs,
  input  wire logic [1:0]  cfgMode,
  // handshake outputs
  output logic             waitOutN,
  output logic             transferAckOutN,
  // array strobes
  output logic      [3:0]  rowStrobeN,
  output logic      [3:0]  colStrobeN
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (CNT_W != 24 || LO_W < 1 || LO_W >= CNT_W) begin : g_badParam
    $error("vrwt_timing: counter widths not supported");
  end

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic [1:0] rstSync_q;  // two-stage release of the async reset
  logic       rstN;       // reset copy used by the whole block

  // async assert, clocked release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstSync_q <= 2'h0;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end
  assign rstN = rstSync_q[1];

  // ---------------------------------------------------------------
  // pin synchronisers: three flops, accept when last two agree
  // ---------------------------------------------------------------
  localparam int NPIN = 10;
  logic [NPIN-1:0] pinRaw;   // all pins from outside the clock domain
  logic [NPIN-1:0] pinS1_q;  // first stage, read by second only
  logic [NPIN-1:0] pinS2_q;
  logic [NPIN-1:0] pinS3_q;
  logic [NPIN-1:0] pin_q;    // filtered copy used by the logic

  assign pinRaw = {cfgMode, bankSelectInputs, columnStrobeEnableN, secondPortGrant,
                   refreshRequestN, extraWaitInN, accessRequestN};

  for (genvar gi = 0; gi < NPIN; gi++) begin : g_sync
    // reset value 1 keeps active-low pins idle; selection pins recover in 4 clocks
    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        pinS1_q[gi] <= 1'b1;
        pinS2_q[gi] <= 1'b1;
        pinS3_q[gi] <= 1'b1;
        pin_q[gi]   <= 1'b1;
      end else begin
        pinS1_q[gi] <= pinRaw[gi];
        pinS2_q[gi] <= pinS1_q[gi];
        pinS3_q[gi] <= pinS2_q[gi];
        // a single glitchy sample is ignored
        pin_q[gi]   <= (pinS2_q[gi] == pinS3_q[gi]) ? pinS3_q[gi] : pin_q[gi];
      end
    end
  end

  logic       accReq;   // access request active
  logic       xWait;    // extra wait requested
  logic       refReq;   // refresh request active
  logic       grant;    // second port grant level
  logic [1:0] colEn;    // column strobe enables, active high
  logic [1:0] bankSel;  // bank select
  logic [1:0] cfg;      // strobe grouping mode
  logic       enAct;    // any column enable active

  assign accReq  = !pin_q[0];
  assign xWait   = !pin_q[1];
  assign refReq  = !pin_q[2];
  assign grant   = pin_q[3];
  assign colEn   = ~pin_q[5:4];
  assign bankSel = pin_q[7:6];
  assign cfg     = pin_q[9:8];
  assign enAct   = |colEn;

  // ---------------------------------------------------------------
  // option register and read port
  // ---------------------------------------------------------------
  logic [vrwt_pkg::OPT_W-1:0] opt_q;     // programmed options
  logic [vrwt_pkg::OPT_W-1:0] opt_d;
  logic [31:0]                rdData_d;
  logic [CNT_W-1:0]           refCnt_q;  // refresh row counter
  logic                       testMode;

  // options change only on a programming write
  always_comb begin
    opt_d    = opt_q;
    rdData_d = 32'h0000_0000;
    if (regWr && regAddr == vrwt_pkg::OFS_OPTIONS) begin
      opt_d = regWrData[vrwt_pkg::OPT_W-1:0];
    end
    if (regRd) begin
      case (regAddr)
        vrwt_pkg::OFS_OPTIONS: rdData_d = {{(32-vrwt_pkg::OPT_W){1'b0}}, opt_q};
        vrwt_pkg::OFS_STATUS:  rdData_d = {{(31-CNT_W){1'b0}}, testMode, refCnt_q};
        default:               rdData_d = 32'h0000_0000;  // unmapped reads zero
      endcase
    end
  end

  // register the options and read data
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      opt_q     <= vrwt_pkg::OPT_RESET;
      regRdData <= 32'h0000_0000;
    end else begin
      opt_q     <= opt_d;
      regRdData <= rdData_d;
    end
  end

  logic       optStyle;    // 0 wait, 1 acknowledge
  logic       optXWait;    // extra edges select
  logic [1:0] optBurst;
  logic [1:0] optFirst;
  logic [1:0] optRef;
  logic       optStagger;

  assign optStyle   = opt_q[vrwt_pkg::POS_STYLE];
  assign optXWait   = opt_q[vrwt_pkg::POS_XWAIT];
  assign optBurst   = opt_q[vrwt_pkg::POS_BURST +: 2];
  assign optFirst   = opt_q[vrwt_pkg::POS_FIRSTDLY +: 2];
  assign optRef     = opt_q[vrwt_pkg::POS_REFTIME +: 2];
  assign optStagger = opt_q[vrwt_pkg::POS_STAGGER];
  assign testMode   = optStagger && opt_q[vrwt_pkg::POS_SCRUB];

  // ---------------------------------------------------------------
  // refresh timing table
  // ---------------------------------------------------------------
  logic [2:0] lowTime;  // strobe low edges
  logic [2:0] preTime;  // precharge edges
  logic       grantTwo; // grant change costs two edges

  // pick refresh low and precharge figures
  always_comb begin
    case (optRef)
      2'h0:    begin lowTime = vrwt_pkg::LOW_00; preTime = vrwt_pkg::PRE_00; end
      2'h1:    begin lowTime = vrwt_pkg::LOW_01; preTime = vrwt_pkg::PRE_01; end
      2'h2:    begin lowTime = vrwt_pkg::LOW_10; preTime = vrwt_pkg::PRE_10; end
      default: begin lowTime = vrwt_pkg::LOW_11; preTime = vrwt_pkg::PRE_11; end
    endcase
  end
  assign grantTwo = optRef[0];  // options 01 and 11

  // ---------------------------------------------------------------
  // bank and column selection
  // ---------------------------------------------------------------
  logic [3:0] rasSel;  // banks selected for an access
  logic [3:0] casSel;  // column strobes selected

  // grouping: 0 all, 1 pairs by upper bit, else singles
  always_comb begin
    case (cfg)
      2'h0:    rasSel = 4'hF;
      2'h1:    rasSel = bankSel[1] ? 4'hC : 4'h3;
      default: rasSel = 4'h1 << bankSel;
    endcase
    casSel = (cfg == 2'h3) ? rasSel : ((cfg == 2'h0) ? 4'hF : rasSel);
  end

  // ---------------------------------------------------------------
  // main sequencer
  // ---------------------------------------------------------------
  vrwt_pkg::vrwt_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d;        // refresh and precharge edge count
  logic [2:0] edge_q, edge_d;      // edges since access strobe went low
  logic       grantPrev_q;         // last seen grant level
  logic       grantHold_q, grantHold_d;  // second edge still blocked
  logic       pend_q, pend_d;      // request seen while busy
  logic       delayed_q, delayed_d;// current access was held off
  logic       xw_q, xw_d;          // extra wait caught at strobe
  logic [3:0] bank_q, bank_d;      // latched access banks
  logic [CNT_W-1:0] refCnt_d;
  logic       grantChg;
  logic       blocked;
  logic [2:0] refEnd;              // last edge of a refresh

  assign grantChg = grant != grantPrev_q;
  // first allowed start is the edge after the change, or the one after that
  assign blocked  = grantChg || grantHold_q;
  assign refEnd   = lowTime - 3'h1 + (optStagger ? vrwt_pkg::STAGGER_SPAN : 3'h0);

  // next state of the sequencer
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    edge_d      = (edge_q == 3'h7) ? edge_q : edge_q + 3'h1;
    grantHold_d = grantChg && grantTwo;
    pend_d      = pend_q;
    delayed_d   = delayed_q;
    xw_d        = xw_q;
    bank_d      = bank_q;
    refCnt_d    = refCnt_q;
    case (state_q)
      vrwt_pkg::ST_IDLE: begin
        if (refReq) begin
          // refresh wins over an access
          state_d = vrwt_pkg::ST_REFRESH;
          cnt_d   = 3'h0;
          pend_d  = pend_q || accReq;
        end else if (accReq && blocked) begin
          pend_d = 1'b1;
        end else if (accReq) begin
          state_d   = vrwt_pkg::ST_ACCESS;
          edge_d    = 3'h0;
          delayed_d = pend_q;
          pend_d    = 1'b0;
          xw_d      = xWait;
          bank_d    = rasSel;
        end
      end
      vrwt_pkg::ST_ACCESS: begin
        if (!accReq) begin
          state_d = vrwt_pkg::ST_PRECHARGE;
          cnt_d   = 3'h0;
        end
      end
      vrwt_pkg::ST_REFRESH: begin
        pend_d = pend_q || accReq;
        cnt_d  = cnt_q + 3'h1;
        if (cnt_q == refEnd) begin
          state_d = vrwt_pkg::ST_PRECHARGE;
          cnt_d   = 3'h0;
          if (testMode) begin
            // two independent counters, both step
            refCnt_d = {refCnt_q[CNT_W-1:LO_W] + 1'b1, refCnt_q[LO_W-1:0] + 1'b1};
          end else begin
            refCnt_d = refCnt_q + 1'b1;
          end
        end
      end
      vrwt_pkg::ST_PRECHARGE: begin
        pend_d = pend_q || accReq;
        cnt_d  = cnt_q + 3'h1;
        if (cnt_q == preTime - 3'h1) begin
          state_d = vrwt_pkg::ST_IDLE;
        end
      end
      default: state_d = vrwt_pkg::ST_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q     <= vrwt_pkg::ST_IDLE;
      cnt_q       <= 3'h0;
      edge_q      <= 3'h0;
      grantPrev_q <= 1'b1;
      grantHold_q <= 1'b0;
      pend_q      <= 1'b0;
      delayed_q   <= 1'b0;
      xw_q        <= 1'b0;
      bank_q      <= 4'h0;
      refCnt_q    <= '0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      edge_q      <= edge_d;
      grantPrev_q <= grant;
      grantHold_q <= grantHold_d;
      pend_q      <= pend_d;
      delayed_q   <= delayed_d;
      xw_q        <= xw_d;
      bank_q      <= bank_d;
      refCnt_q    <= refCnt_d;
    end
  end

  // ---------------------------------------------------------------
  // first-access and burst handshake timing
  // ---------------------------------------------------------------
  logic       inAccess;
  logic [2:0] needPos;       // whole edges before ready
  logic       needHalf;      // plus one low clock level
  logic       halfReady_q;   // set on the falling edge once edges are met
  logic       enLow_q;       // enables seen active on a falling edge
  logic       firstReady;
  logic       firstDone_q, firstDone_d;
  logic       burstHold_q, burstHold_d;
  logic       burstWait;
  logic       ready;

  assign inAccess = state_q == vrwt_pkg::ST_ACCESS;

  // first-access delay per style and option
  always_comb begin
    case (optFirst)
      2'h0:    begin needPos = 3'h0; needHalf = 1'b0; end
      2'h1:    begin needPos = optStyle ? 3'h1 : 3'h0; needHalf = !optStyle; end
      2'h2:    begin needPos = 3'h0; needHalf = optStyle || delayed_q; end
      default: begin needPos = 3'h1; needHalf = optStyle; end
    endcase
    if (xw_q) begin
      needPos = needPos + (optXWait ? 3'h2 : 3'h1);
    end
  end

  assign firstReady = inAccess && edge_q >= needPos && (!needHalf || halfReady_q);

  // half-clock points: falling edge of the same clock
  always_ff @(negedge clk or negedge rstN) begin
    if (!rstN) begin
      halfReady_q <= 1'b0;
      enLow_q     <= 1'b0;
    end else begin
      halfReady_q <= inAccess && edge_q >= needPos;
      enLow_q     <= enAct;
    end
  end

  // burst tracking: hold is the enables-off state seen at the last edge
  always_comb begin
    firstDone_d = inAccess && (firstDone_q || firstReady);
    burstHold_d = firstDone_q && accReq && !enAct;
  end

  // burst registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      firstDone_q <= 1'b0;
      burstHold_q <= 1'b0;
    end else begin
      firstDone_q <= firstDone_d;
      burstHold_q <= burstHold_d;
    end
  end

  // burst wait per option
  always_comb begin
    case (optBurst)
      2'h0:    burstWait = 1'b0;
      2'h1:    burstWait = !enAct || burstHold_q;
      2'h2:    burstWait = !enAct || (burstHold_q && !enLow_q);
      default: burstWait = !enAct;
    endcase
  end

  assign ready = firstDone_q ? !burstWait : firstReady;

  // one handshake pin active, the other parked high
  assign waitOutN        = !(!optStyle && accReq && !ready);
  assign transferAckOutN = !(optStyle && accReq && ready);

  // ---------------------------------------------------------------
  // array strobes
  // ---------------------------------------------------------------
  logic [3:0] refRas;  // refresh strobes

  for (genvar gb = 0; gb < 4; gb++) begin : g_ras
    // staggered strobes start one edge apart
    assign refRas[gb] = optStagger ? (cnt_q >= 3'(gb) && cnt_q < 3'(gb) + lowTime) : (cnt_q < lowTime);
  end

  // access strobes from the latched banks, refresh from the table
  always_comb begin
    rowStrobeN = 4'hF;
    if (inAccess) begin
      rowStrobeN = ~bank_q;
    end else if (state_q == vrwt_pkg::ST_REFRESH) begin
      rowStrobeN = ~refRas;
    end
    // each column strobe needs selection and its pair enable
    colStrobeN = ~({4{inAccess}} & casSel & {colEn[1], colEn[1], colEn[0], colEn[0]});
  end

endmodule

// File: verification/vrwt_timing_asserts.sv
// port assertions for the video-RAM timing block
`timescale 1ns/1ns
module vrwt_timing_asserts (
  // clock, reset, option writes
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  // processor side
  input wire logic        accessRequestN,
  input wire logic        extraWaitInN,
  input wire logic [1:0]  columnStrobeEnableN,
  input wire logic        waitOutN,
  input wire logic        transferAckOutN,
  // array side
  input wire logic [3:0]  rowStrobeN,
  input wire logic [3:0]  colStrobeN
);
  // ------
  // shadow
  // ------
  logic [10:0] opt_q;   // last programmed options
  logic [2:0]  low_q;   // cycles all rows held low
  logic [2:0]  expLow;  // wanted refresh low time
  logic        acc;     // some rows low, not all
  logic        allLow;  // all rows low: a refresh
  logic        ackN;    // acknowledge pin
  assign ackN = transferAckOutN;
  assign allLow = rowStrobeN == 4'h0;
  // only sound with stagger off and cfgMode kept nonzero
  assign acc = rowStrobeN != 4'hF && !allLow && !opt_q[9];
  assign expLow = opt_q[0] ? (opt_q[1] ? vrwt_pkg::LOW_11 : vrwt_pkg::LOW_01)
                           : (opt_q[1] ? vrwt_pkg::LOW_10 : vrwt_pkg::LOW_00);
  // options follow writes; counter wrap is harmless
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opt_q <= vrwt_pkg::OPT_RESET;
      low_q <= 3'h0;
    end else begin
      if (regWr && regAddr == vrwt_pkg::OFS_OPTIONS) begin
        opt_q <= regWrData[10:0];
      end
      low_q <= allLow ? low_q + 3'h1 : 3'h0;
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  styleWait_a: assert property (opt_q[7] |-> waitOutN)
    else $error("wait pin moved in ack style");
  styleAck_a: assert property (!opt_q[7] |-> ackN)
    else $error("ack pin moved in wait style");
  ackEarly_a: assert property (opt_q[7] && !opt_q[2] && extraWaitInN && $rose(acc) |-> !ackN)
    else $error("ack late");
  ackLate_a: assert property (opt_q[7] && opt_q[2] && extraWaitInN && $rose(acc) |-> ackN ##1 !ackN)
    else $error("ack not one edge after row");
  extraOne_a: assert property (opt_q[7] && opt_q[6:2] == 5'h00 && !extraWaitInN && $rose(acc)
    |-> ackN ##1 !ackN)
    else $error("single extra wait wrong");
  extraTwo_a: assert property (opt_q[7] && opt_q[6:2] == 5'h10 && !extraWaitInN && $rose(acc)
    |-> ackN [*2] ##1 !ackN)
    else $error("double extra wait wrong");
  burstHold_a: assert property (opt_q[7] && opt_q[5:4] == 2'h0 && acc && !accessRequestN && !ackN |=> !ackN)
    else $error("burst wait inserted");
  // enables reach the logic four edges after the pin: three sync flops and the filter
  burstFollow_a: assert property (opt_q[7] && opt_q[5:4] == 2'h3 && acc
    && $past(columnStrobeEnableN, 4) == 2'h3 |-> ackN)
    else $error("ack ignores column enables");
  colGate_a: assert property (colStrobeN != 4'hF
    |-> (colStrobeN[1:0] == 2'h3 || !$past(columnStrobeEnableN[0], 4))
    && (colStrobeN[3:2] == 2'h3 || !$past(columnStrobeEnableN[1], 4)))
    else $error("column strobe without enable");
  refreshLow_a: assert property ($fell(allLow) && !opt_q[9] |-> low_q == expLow)
    else $error("refresh low time wrong");
endmodule

bind vrwt_timing vrwt_timing_asserts i_vrwt_timing_asserts (
  .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
  .accessRequestN(accessRequestN), .extraWaitInN(extraWaitInN), .columnStrobeEnableN(columnStrobeEnableN),
  .waitOutN(waitOutN), .transferAckOutN(transferAckOutN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN)
);

// File: verification/vrwt_cpu_model.sv
// processor model: requests accesses, drives extra wait and column enables
`timescale 1ns/1ns
module vrwt_cpu_model (
  // command from the bench
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       style,
  input  wire logic       xwLow,
  input  wire logic [3:0] holdCycles,
  input  wire logic       dropEnables,
  // answers from the design
  input  wire logic       waitOutN,
  input  wire logic       transferAckOutN,
  input  wire logic [3:0] rowStrobeN,
  // pins to the design, then busy and late to the bench
  output logic            accessRequestN,
  output logic            extraWaitInN,
  output logic [1:0]      columnStrobeEnableN,
  output logic            busy,
  output logic            late   // no answer within the bound
);
  int n;  // bound on every wait
  // one access per go pulse; the request is held until ready is seen
  initial begin
    accessRequestN = 1'b1;
    extraWaitInN = 1'b1;
    columnStrobeEnableN = 2'h0;
    busy = 1'b0;
    late = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        late <= 1'b0;
        extraWaitInN <= !xwLow;
        // extra wait settles before the request so it is seen at start
        repeat (4) @(posedge clk);
        accessRequestN <= 1'b0;
        for (n = 0; n < 40 && !(rowStrobeN != 4'hF && (style ? !transferAckOutN : waitOutN)); n++) @(posedge clk);
        if (n == 40) late <= 1'b1;
        // burst part: optionally pull the enables away for two cycles
        if (dropEnables) begin
          columnStrobeEnableN <= 2'h3;
          repeat (2) @(posedge clk);
          columnStrobeEnableN <= 2'h0;
        end
        repeat (holdCycles) @(posedge clk);
        accessRequestN <= 1'b1;
        for (n = 0; n < 40 && rowStrobeN != 4'hF; n++) @(posedge clk);
        if (n == 40) late <= 1'b1;
        extraWaitInN <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: verification/vrwt_timing_bench.sv
// self-checking bench for the video-RAM timing block
`timescale 1ns/1ns
module vrwt_timing_bench;
  // -------
  // signals
  // -------
  logic        clk, arst_n, regWr, regRd;          // clock, reset, strobes
  logic [3:0]  regAddr, holdCycles, rowStrobeN, colStrobeN;
  logic [31:0] regWrData, regRdData, d, opt, cnt;
  logic        refreshRequestN, secondPortGrant;  // bench-owned pins
  logic [1:0]  bankSelectInputs, cfgMode, columnStrobeEnableN;
  logic        go, style, xwLow, dropEnables, busy, late;  // partner command and status
  logic        accessRequestN, extraWaitInN, waitOutN, transferAckOutN;
  int          bad_count, compares, seed;

  vrwt_timing i_vrwt_timing (
    .clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .accessRequestN(accessRequestN), .extraWaitInN(extraWaitInN),
    .refreshRequestN(refreshRequestN), .secondPortGrant(secondPortGrant),
    .columnStrobeEnableN(columnStrobeEnableN), .bankSelectInputs(bankSelectInputs), .cfgMode(cfgMode),
    .waitOutN(waitOutN), .transferAckOutN(transferAckOutN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN));
  vrwt_cpu_model i_vrwt_cpu_model (
    .clk(clk), .go(go), .style(style), .xwLow(xwLow), .holdCycles(holdCycles), .dropEnables(dropEnables),
    .waitOutN(waitOutN), .transferAckOutN(transferAckOutN), .rowStrobeN(rowStrobeN),
    .accessRequestN(accessRequestN), .extraWaitInN(extraWaitInN), .columnStrobeEnableN(columnStrobeEnableN),
    .busy(busy), .late(late));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // -----
  // tasks
  // -----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // strobes drop with a gap cycle so no pin is driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    v = regRdData;
    @(posedge clk);
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic waitIdle;
    int n;
    for (n = 0; n < 300 && (busy || n < 2); n++) @(posedge clk);
    chk(busy, 1'b0);
    chk(late, 1'b0);
    if (busy) summarize();
  endtask
  task automatic access(input logic x, input logic [3:0] h, input logic dr);
    xwLow <= x;
    holdCycles <= h;
    dropEnables <= dr;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    waitIdle();
  endtask
  // refresh low and precharge edges per timing option
  function automatic logic [5:0] times(input logic [1:0] t);
    case (t)
      2'h0: return {vrwt_pkg::LOW_00, vrwt_pkg::PRE_00};
      2'h1: return {vrwt_pkg::LOW_01, vrwt_pkg::PRE_01};
      2'h2: return {vrwt_pkg::LOW_10, vrwt_pkg::PRE_10};
      default: return {vrwt_pkg::LOW_11, vrwt_pkg::PRE_11};
    endcase
  endfunction
  // test mode: both counter halves step
  function automatic logic [31:0] split(input logic [31:0] c);
    return {7'h0, 1'b1, c[23:13] + 11'h1, c[12:0] + 13'h1};
  endfunction
  // one refresh, optionally with an access queued behind it
  task automatic refresh(input logic stag, input logic acc, input logic [5:0] lp);
    int n, b, len, endc, acs;
    int fall[4];
    logic [3:0] r, pr;
    len = 0;
    endc = -1;
    acs = -1;
    pr = 4'hF;
    fall = '{-1, -1, -1, -1};
    refreshRequestN <= 1'b0;
    go <= acc;
    xwLow <= 1'b0;
    dropEnables <= 1'b0;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      go <= 1'b0;
      // two edges pass the pin filter; a longer request outlives a short refresh
      if (n == 1) refreshRequestN <= 1'b1;
      #1;
      r = rowStrobeN;
      for (b = 0; b < 4; b++) if (!r[b] && fall[b] < 0) fall[b] = n;
      if (r == 4'h0) len++;
      if (pr == 4'h0 && r == 4'hF) endc = n;
      if (r != 4'hF && r != 4'h0 && endc >= 0 && acs < 0) acs = n;
      pr = r;
    end
    if (stag) begin
      for (b = 1; b < 4; b++) chk(fall[b] - fall[0], b);
    end else begin
      chk(len, lp[5:3]);
      chk(acs - endc >= lp[2:0], 1'b1);
    end
    if (acc) waitIdle();
  endtask

  // ----
  // main
  // ----
  initial begin
    {arst_n, regWr, regRd, secondPortGrant, go, style, xwLow, dropEnables} = 8'h00;
    {regAddr, regWrData, holdCycles, bankSelectInputs} = '0;
    refreshRequestN = 1'b1;
    cfgMode = 2'h1;
    bad_count = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    seed = $urandom(89);
    // reset value, then an unmapped read
    rd(vrwt_pkg::OFS_OPTIONS, d);
    chk(d, vrwt_pkg::OPT_RESET);
    rd(4'hC, d);
    chk(d, 32'h0);
    // every refresh timing option, acknowledge style
    for (int i = 0; i < 4; i++) begin
      wr(vrwt_pkg::OFS_OPTIONS, 32'h80 | i);
      style <= 1'b1;
      refresh(1'b0, 1'b1, times(i[1:0]));
    end
    // corners first: each delay in both styles, then extra waits; then random
    for (int i = 0; i < 32; i++) begin
      opt = $urandom & 32'h5FF;
      if (i < 8) opt = {3'h0, i[2], 1'b0, 2'h0, i[1:0], 2'h0};
      if (i >= 8 && i < 12) opt = {3'h0, 1'b1, i[0], {2{i[1]}}, 4'h0};
      wr(vrwt_pkg::OFS_OPTIONS, opt);
      rd(vrwt_pkg::OFS_OPTIONS, d);
      chk(d, opt);
      style <= opt[7];
      cfgMode <= 2'h1 + 2'($urandom % 3);
      bankSelectInputs <= 2'($urandom);
      secondPortGrant <= ~secondPortGrant;
      access(i < 8 ? 1'b0 : (i < 12 ? 1'b1 : 1'($urandom)), 4'($urandom), i >= 8 || 1'($urandom));
    end
    // stagger plus scrubbing: test mode, split counter, spaced strobes
    rd(vrwt_pkg::OFS_STATUS, cnt);
    chk(cnt, 32'h4);
    wr(vrwt_pkg::OFS_OPTIONS, 32'h600);
    rd(vrwt_pkg::OFS_STATUS, d);
    chk(d[vrwt_pkg::POS_TESTMODE], 1'b1);
    refresh(1'b1, 1'b0, times(2'h0));
    rd(vrwt_pkg::OFS_STATUS, d);
    chk(d, split(cnt));
    wr(vrwt_pkg::OFS_OPTIONS, 32'h400);
    rd(vrwt_pkg::OFS_STATUS, d);
    chk(d[vrwt_pkg::POS_TESTMODE], 1'b0);
    summarize();
  end
endmodule
